// >>> shared/isc_cfg.svh
// constants for the two-wire slave port: address, bit counts, buffer depth
`ifndef ISC_CFG_SVH
`define ISC_CFG_SVH

// fixed upper five bits of the seven-bit slave address
`define ISC_ADDR_FIXED 5'h10
// direction bit value meaning master writes to the device
`define ISC_DIR_WRITE 1'b0
// bit counter values inside one byte
`define ISC_BIT_LAST 4'h7
`define ISC_BIT_FULL 4'h8
`define ISC_BIT_ZERO 4'h0
// depth of the receive buffer toward the user side
`define ISC_FIFO_DEPTH 2
// link clock period used by the bench, in ns
`define ISC_LINK_PERIOD_NS 80

`endif

// >>> shared/isc_pkg.sv
// types shared by the two-wire slave port modules
package isc_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_RXWAIT,
    ST_ACK,
    ST_TXWAIT,
    ST_TX,
    ST_TACK
  } isc_state_e;

  typedef struct packed {
    logic is_cmd;
    logic [7:0] data;
  } isc_word_s;

endpackage

// >>> shared/isc_strm_if.sv
// valid/ready stream of received words between the port modules
`timescale 1ns/1ns
`default_nettype none
interface isc_strm_if;
  logic valid;
  logic ready;
  isc_pkg::isc_word_s word;

  modport src (output valid, output word, input ready);
  modport snk (input valid, input word, output ready);
endinterface
`default_nettype wire

// >>> core/isc_sync.sv
// two-flop synchroniser for a group of independent level signals
`timescale 1ns/1ns
`default_nettype none
module isc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // asynchronous levels in, synchronised levels out
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  logic [W-1:0] meta_q;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_q <= '0;
      o_q <= '0;
    end else begin
      meta_q <= i_d;
      o_q <= meta_q;
    end
  end

endmodule
`default_nettype wire

// >>> core/isc_fifo2.sv
// small flop buffer with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
`include "isc_cfg.svh"
module isc_fifo2 #(
  parameter int DEPTH = `ISC_FIFO_DEPTH
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // filling and draining sides
  isc_strm_if.snk wr,
  isc_strm_if.src rd
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  isc_pkg::isc_word_s mem_q [DEPTH];
  logic [PW-1:0] wptr_q;
  logic [PW-1:0] rptr_q;
  logic [CW-1:0] count_q;
  logic push;
  logic pop;

  assign wr.ready = (count_q != CW'(DEPTH));
  assign rd.valid = (count_q != '0);
  assign rd.word = mem_q[rptr_q];
  assign push = wr.valid && wr.ready;
  assign pop = rd.valid && rd.ready;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    if (p == PW'(DEPTH - 1)) begin
      bump = '0;
    end else begin
      bump = p + 1'b1;
    end
  endfunction

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else if (push) begin
      mem_q[wptr_q] <= wr.word;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wptr_q <= '0;
      rptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wptr_q <= bump(wptr_q);
      end
      if (pop) begin
        rptr_q <= bump(rptr_q);
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// >>> core/isc_slave.sv
// two-wire bus slave with clock stretching, link engine and user-side crossing
`timescale 1ns/1ns
`default_nettype none
`include "isc_cfg.svh"
module isc_slave (
  // system clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // link clock oversampling the bus
  input wire logic i_link_clk,
  // bus clock line, open drain
  input wire logic i_scl,
  output logic o_scl,
  output logic o_scl_oe,
  // bus data line, open drain
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  // address select straps
  input wire logic i_addr_select_pin_hi,
  input wire logic i_addr_select_pin_lo,
  // received bytes toward the user
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  output logic o_rx_is_cmd,
  input wire logic i_rx_ready,
  // bytes to transmit from the user
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  output logic o_tx_ready,
  output logic o_tx_status,
  // bus state toward the user
  output logic o_bus_busy,
  output logic o_xfer_end
);

  ////////////////////////////////////////////////////////////////////////
  // link domain: synchronised inputs and edge detection

  logic [5:0] lk_sync;
  logic scl_s;
  logic sda_s;
  logic pin_hi_s;
  logic pin_lo_s;
  logic rx_ack_s;
  logic tx_ack_s;
  logic scl_p_q;
  logic sda_p_q;
  logic rx_seen_q;
  logic tx_seen_q;

  isc_sync #(.W(6)) u_lk_sync (
    .i_clk(i_link_clk),
    .i_rstn(i_rstn),
    .i_d({!i_scl, !i_sda, i_addr_select_pin_hi, i_addr_select_pin_lo, rx_seen_q, tx_seen_q}),
    .o_q(lk_sync)
  );

  // bus lines pass inverted so the cleared synchroniser reads as an idle high bus
  assign scl_s = !lk_sync[5];
  assign sda_s = !lk_sync[4];
  assign {pin_hi_s, pin_lo_s, rx_ack_s, tx_ack_s} = lk_sync[3:0];

  // idle value is high so a bus at rest gives no false edge after reset
  always_ff @(posedge i_link_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  logic start_det;
  logic stop_det;
  logic scl_rise;
  logic scl_fall;

  assign start_det = scl_s && scl_p_q && sda_p_q && !sda_s;
  assign stop_det = scl_s && scl_p_q && !sda_p_q && sda_s;
  assign scl_rise = scl_s && !scl_p_q;
  assign scl_fall = !scl_s && scl_p_q;

  ////////////////////////////////////////////////////////////////////////
  // link domain: bus state

  logic busy_q;
  logic stop_tgl_q;

  always_ff @(posedge i_link_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      busy_q <= 1'b0;
      stop_tgl_q <= 1'b0;
    end else if (start_det) begin
      busy_q <= 1'b1;
    end else if (stop_det) begin
      busy_q <= 1'b0;
      stop_tgl_q <= !stop_tgl_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // link domain: byte engine

  isc_pkg::isc_state_e st_q;
  logic [7:0] sh_q;
  logic [3:0] cnt_q;
  logic addr_ph_q;
  logic first_q;
  logic rd_q;
  logic cmd_seen_q;
  logic status_mode_q;
  logic mst_ack_q;
  logic scl_oe_q;
  logic sda_oe_q;
  logic rx_req_q;
  logic tx_req_q;
  isc_pkg::isc_word_s rx_word_q;
  logic [7:0] tx_data_q;
  logic addr_hit;

  assign addr_hit = (sh_q[7:1] == {`ISC_ADDR_FIXED, pin_hi_s, pin_lo_s});

  always_ff @(posedge i_link_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_q <= isc_pkg::ST_IDLE;
      sh_q <= 8'h00;
      cnt_q <= `ISC_BIT_ZERO;
      addr_ph_q <= 1'b0;
      first_q <= 1'b0;
      rd_q <= 1'b0;
      cmd_seen_q <= 1'b0;
      status_mode_q <= 1'b0;
      mst_ack_q <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      rx_req_q <= 1'b0;
      tx_req_q <= 1'b0;
      rx_word_q <= '0;
    end else if (start_det) begin
      // repeated start keeps the command history for an addressed read
      st_q <= isc_pkg::ST_RX;
      addr_ph_q <= 1'b1;
      cnt_q <= `ISC_BIT_ZERO;
      sda_oe_q <= 1'b0;
      scl_oe_q <= 1'b0;
    end else if (stop_det) begin
      st_q <= isc_pkg::ST_IDLE;
      cmd_seen_q <= 1'b0;
      sda_oe_q <= 1'b0;
      scl_oe_q <= 1'b0;
    end else begin
      case (st_q)
        isc_pkg::ST_RX: begin
          if (scl_rise) begin
            sh_q <= {sh_q[6:0], sda_s};
            cnt_q <= cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == `ISC_BIT_FULL) begin
            cnt_q <= `ISC_BIT_ZERO;
            if (addr_ph_q) begin
              addr_ph_q <= 1'b0;
              if (addr_hit) begin
                rd_q <= (sh_q[0] != `ISC_DIR_WRITE);
                status_mode_q <= !cmd_seen_q;
                first_q <= 1'b1;
                sda_oe_q <= 1'b1;
                st_q <= isc_pkg::ST_ACK;
              end else begin
                st_q <= isc_pkg::ST_IDLE;
              end
            end else begin
              rx_word_q <= '{is_cmd: first_q, data: sh_q};
              rx_req_q <= !rx_req_q;
              if (first_q) begin
                cmd_seen_q <= 1'b1;
              end
              first_q <= 1'b0;
              scl_oe_q <= 1'b1;
              st_q <= isc_pkg::ST_RXWAIT;
            end
          end
        end
        isc_pkg::ST_RXWAIT: begin
          // ack only once the word sits in the buffer
          if (rx_ack_s == rx_req_q) begin
            sda_oe_q <= 1'b1;
            st_q <= isc_pkg::ST_ACK;
          end
        end
        isc_pkg::ST_ACK: begin
          // scl is let go one cycle after sda settles, keeping data setup
          if (scl_oe_q) begin
            scl_oe_q <= 1'b0;
          end else if (scl_fall) begin
            sda_oe_q <= 1'b0;
            if (rd_q) begin
              tx_req_q <= !tx_req_q;
              scl_oe_q <= 1'b1;
              st_q <= isc_pkg::ST_TXWAIT;
            end else begin
              st_q <= isc_pkg::ST_RX;
            end
          end
        end
        isc_pkg::ST_TXWAIT: begin
          if (tx_ack_s == tx_req_q) begin
            sh_q <= tx_data_q;
            sda_oe_q <= !tx_data_q[7];
            cnt_q <= `ISC_BIT_ZERO;
            st_q <= isc_pkg::ST_TX;
          end
        end
        isc_pkg::ST_TX: begin
          // bits change only after scl has been seen low
          if (scl_oe_q) begin
            scl_oe_q <= 1'b0;
          end else if (scl_fall) begin
            if (cnt_q == `ISC_BIT_LAST) begin
              sda_oe_q <= 1'b0;
              st_q <= isc_pkg::ST_TACK;
            end else begin
              sda_oe_q <= !sh_q[6];
              sh_q <= {sh_q[6:0], 1'b0};
              cnt_q <= cnt_q + 4'h1;
            end
          end
        end
        isc_pkg::ST_TACK: begin
          if (scl_rise) begin
            mst_ack_q <= !sda_s;
          end else if (scl_fall) begin
            if (mst_ack_q) begin
              tx_req_q <= !tx_req_q;
              scl_oe_q <= 1'b1;
              st_q <= isc_pkg::ST_TXWAIT;
            end else begin
              st_q <= isc_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          st_q <= isc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // lines are only ever pulled low; the pull-up makes the high level
  assign o_scl = 1'b0;
  assign o_sda = 1'b0;
  assign o_scl_oe = scl_oe_q;
  assign o_sda_oe = sda_oe_q;

  ////////////////////////////////////////////////////////////////////////
  // system domain: toggle handshakes back from the link

  logic [3:0] sy_sync;
  logic rx_req_s;
  logic tx_req_s;
  logic stop_s;
  logic stop_seen_q;
  logic tx_status_q;
  logic xfer_end_q;
  logic [7:0] tx_hold_q;

  isc_sync #(.W(4)) u_sy_sync (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_d({rx_req_q, tx_req_q, busy_q, stop_tgl_q}),
    .o_q(sy_sync)
  );

  assign {rx_req_s, tx_req_s, o_bus_busy, stop_s} = sy_sync;

  isc_strm_if rx_in ();
  isc_strm_if rx_out ();

  // rx_word_q is stable while its toggle is outstanding
  assign rx_in.valid = (rx_req_s != rx_seen_q);
  assign rx_in.word = rx_word_q;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rx_seen_q <= 1'b0;
    end else if (rx_in.valid && rx_in.ready) begin
      rx_seen_q <= rx_req_s;
    end
  end

  isc_fifo2 #(.DEPTH(`ISC_FIFO_DEPTH)) u_rx_fifo (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .wr(rx_in),
    .rd(rx_out)
  );

  assign o_rx_valid = rx_out.valid;
  assign o_rx_data = rx_out.word.data;
  assign o_rx_is_cmd = rx_out.word.is_cmd;
  assign rx_out.ready = i_rx_ready;

  // a fetch stays open until the user supplies a byte; scl stretches meanwhile
  assign o_tx_ready = (tx_req_s != tx_seen_q);

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tx_seen_q <= 1'b0;
      tx_hold_q <= 8'h00;
      tx_status_q <= 1'b0;
    end else begin
      if (o_tx_ready) begin
        tx_status_q <= status_mode_q;
      end
      if (i_tx_valid && o_tx_ready) begin
        tx_hold_q <= i_tx_data;
        tx_seen_q <= tx_req_s;
      end
    end
  end

  assign tx_data_q = tx_hold_q;
  assign o_tx_status = tx_status_q;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      stop_seen_q <= 1'b0;
      xfer_end_q <= 1'b0;
    end else begin
      stop_seen_q <= stop_s;
      xfer_end_q <= (stop_s != stop_seen_q);
    end
  end

  assign o_xfer_end = xfer_end_q;

endmodule
`default_nettype wire

// >>> dv/isc_slave_monitor.sv
// assertions on the two-wire slave port pins and user streams
`timescale 1ns/1ns
`default_nettype none
module isc_slave_monitor (
  // clocks and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_link_clk,
  // bus lines
  input wire logic i_scl,
  input wire logic o_scl_oe,
  input wire logic i_sda,
  input wire logic o_sda_oe,
  // user side
  input wire logic o_rx_valid,
  input wire logic [7:0] o_rx_data,
  input wire logic o_rx_is_cmd,
  input wire logic i_rx_ready,
  input wire logic i_tx_valid,
  input wire logic o_tx_ready,
  input wire logic o_bus_busy,
  input wire logic o_xfer_end
);
  property p_sda_stable;
    @(posedge i_link_clk) disable iff (!i_rstn) i_scl && $past(i_scl) |-> $stable(o_sda_oe);
  endproperty
  a_sda_stable: assert property (p_sda_stable) else $error("sda moved with scl high");
  // a hold may only extend a low phase that the master began
  property p_stretch_low;
    @(posedge i_link_clk) disable iff (!i_rstn) $rose(o_scl_oe) |-> !$past(i_scl);
  endproperty
  a_stretch_low: assert property (p_stretch_low) else $error("scl held from high");
  property p_idle_free;
    @(posedge i_clk) disable iff (!i_rstn) !o_bus_busy |-> !o_scl_oe && !o_sda_oe;
  endproperty
  a_idle_free: assert property (p_idle_free) else $error("line pulled while idle");
  // raw sampling plus the slave's own synchroniser gives the window
  property p_busy_start;
    @(posedge i_link_clk) disable iff (!i_rstn)
      i_scl && $past(i_scl) && $fell(i_sda) |-> ##[1:5] o_bus_busy;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("start not seen");
  property p_end_pulse;
    @(posedge i_clk) disable iff (!i_rstn) o_xfer_end |=> !o_xfer_end;
  endproperty
  a_end_pulse: assert property (p_end_pulse) else $error("stop pulse too long");
  property p_end_busy;
    @(posedge i_clk) disable iff (!i_rstn) $rose(o_xfer_end) |-> ##[0:4] !o_bus_busy;
  endproperty
  a_end_busy: assert property (p_end_busy) else $error("busy after stop");
  property p_rx_hold;
    @(posedge i_clk) disable iff (!i_rstn) o_rx_valid && !i_rx_ready
      |=> o_rx_valid && $stable(o_rx_data) && $stable(o_rx_is_cmd);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx word lost while stalled");
  property p_tx_take;
    @(posedge i_clk) disable iff (!i_rstn) o_tx_ready && i_tx_valid |=> !o_tx_ready;
  endproperty
  a_tx_take: assert property (p_tx_take) else $error("tx ready after take");
  c_stretch: cover property (@(posedge i_link_clk) $rose(o_scl_oe));
  c_rx_take: cover property (@(posedge i_clk) o_rx_valid && i_rx_ready);
  c_tx_take: cover property (@(posedge i_clk) o_tx_ready && i_tx_valid);
  c_stop: cover property (@(posedge i_clk) o_xfer_end);
endmodule
bind isc_slave isc_slave_monitor u_mon (.i_clk, .i_rstn, .i_link_clk, .i_scl, .o_scl_oe,
  .i_sda, .o_sda_oe, .o_rx_valid, .o_rx_data, .o_rx_is_cmd, .i_rx_ready, .i_tx_valid,
  .o_tx_ready, .o_bus_busy, .o_xfer_end);
`default_nettype wire

// >>> dv/isc_master.sv
// behavioural two-wire bus master facing the slave port
`timescale 1ns/1ns
`default_nettype none
module isc_master #(
  parameter int Q = 24
) (
  // system clock paces the bus timing
  input wire logic i_clk,
  // resolved line levels
  input wire logic i_scl,
  input wire logic i_sda,
  // pull-down enables, high while pulling low
  output logic o_scl_oe,
  output logic o_sda_oe
);
  initial begin
    o_scl_oe = 1'b0;
    o_sda_oe = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // the slave may keep the line low; bounded so a hang ends in the bench
  task automatic scl_up();
    int n = 0;
    o_scl_oe <= 1'b0;
    while (!i_scl && n < 40000) begin
      @(posedge i_clk);
      n++;
    end
  endtask
  task automatic xbit(input logic b, output logic r);
    logic r1;
    o_sda_oe <= !b;
    w(2 * Q);
    scl_up();
    r1 = i_sda;
    w(2 * Q);
    r = (r1 === i_sda) ? r1 : 1'bx;
    o_scl_oe <= 1'b1;
  endtask
  // long lead-in lets a pending acknowledge drain before a repeated start
  task automatic start();
    o_sda_oe <= 1'b0;
    w(2 * Q);
    scl_up();
    w(Q);
    o_sda_oe <= 1'b1;
    w(Q);
    o_scl_oe <= 1'b1;
  endtask
  task automatic stop();
    o_sda_oe <= 1'b1;
    w(2 * Q);
    scl_up();
    w(Q);
    o_sda_oe <= 1'b0;
    w(2 * Q);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) xbit(d[i], r);
    xbit(1'b1, r);
    ack = !r;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(1'b1, r);
      d[i] = r;
    end
    xbit(last, r);
  endtask
endmodule
`default_nettype wire

// >>> dv/isc_slave_test.sv
// self-checking bench for the two-wire slave port
`timescale 1ns/1ns
`default_nettype none
`include "isc_cfg.svh"
module isc_slave_test;
  logic i_clk = 1'b0, i_link_clk = 1'b0, i_rstn = 1'b0, i_rx_ready = 1'b0, i_tx_valid = 1'b0;
  logic stall = 1'b0, exp_st = 1'b0;
  logic [7:0] i_tx_data = 8'h00;
  logic [1:0] pins = 2'h0;
  logic m_scl_oe, m_sda_oe, o_scl, o_scl_oe, o_sda, o_sda_oe, o_rx_valid, o_rx_is_cmd;
  logic o_tx_ready, o_tx_status, o_bus_busy, o_xfer_end;
  logic [7:0] o_rx_data;
  logic [8:0] rxq[$];
  logic [7:0] txq[$];
  int num_errors = 0, checks = 0, cyc = 0, held = 0;
  // pull-ups: a released line reads high
  wire scl = (o_scl_oe ? o_scl : 1'b1) & !m_scl_oe;
  wire sda = (o_sda_oe ? o_sda : 1'b1) & !m_sda_oe;
  always #5 i_clk = ~i_clk;
  initial begin
    #3;
    forever #40 i_link_clk = ~i_link_clk;
  end
  isc_slave DUT (.i_clk, .i_rstn, .i_link_clk, .i_scl(scl), .o_scl, .o_scl_oe, .i_sda(sda),
    .o_sda, .o_sda_oe, .i_addr_select_pin_hi(pins[1]), .i_addr_select_pin_lo(pins[0]),
    .o_rx_valid, .o_rx_data, .o_rx_is_cmd, .i_rx_ready, .i_tx_valid, .i_tx_data,
    .o_tx_ready, .o_tx_status, .o_bus_busy, .o_xfer_end);
  isc_master u_mst (.i_clk, .i_scl(scl), .i_sda(sda), .o_scl_oe(m_scl_oe), .o_sda_oe(m_sda_oe));
  ////////////////////////////////////////
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    if (num_errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (o_scl_oe) held <= held + 1;
    if (cyc == 60000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  always @(posedge i_clk) begin
    i_rx_ready <= stall ? 1'b0 : 1'($urandom);
    if (o_rx_valid && i_rx_ready) check("rx word", {o_rx_is_cmd, o_rx_data},
      rxq.size() ? rxq.pop_front() : 9'h1FF);
  end
  // a byte is noted as expected only when the slave takes it
  always @(posedge i_clk) begin
    if (i_tx_valid && o_tx_ready) begin
      check("tx status", o_tx_status, exp_st);
      txq.push_back(i_tx_data);
      i_tx_valid <= 1'b0;
      i_tx_data <= 8'($urandom);
    end else if (o_tx_ready && !i_tx_valid) i_tx_valid <= 1'b1;
  end
  task automatic rd_burst(input logic st, input int n);
    logic ack;
    logic [7:0] d;
    exp_st <= st;
    u_mst.start();
    u_mst.wbyte({`ISC_ADDR_FIXED, pins, 1'b1}, ack);
    check("read addr ack", ack, 1'b1);
    check("busy", o_bus_busy, 1'b1);
    for (int i = 0; i < n; i++) begin
      u_mst.rbyte(i == n - 1, d);
      check("read byte", d, txq.size() ? txq.pop_front() : 8'hXX);
    end
    u_mst.w(60);
    check("sda released", sda, 1'b1);
    u_mst.stop();
    u_mst.w(10);
    check("idle", o_bus_busy, 1'b0);
  endtask
  initial begin
    logic ack;
    logic [7:0] d;
    void'($urandom(32'hF3BE7833));
    pins = 2'($urandom);
    repeat (6) @(posedge i_clk);
    i_rstn <= 1'b1;
    u_mst.w(60);
    stall <= 1'b1;
    fork
      begin
        u_mst.w(5500);
        stall <= 1'b0;
      end
    join_none
    u_mst.start();
    u_mst.wbyte({`ISC_ADDR_FIXED, pins, `ISC_DIR_WRITE}, ack);
    check("write addr ack", ack, 1'b1);
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom);
      rxq.push_back({i == 0, d});
      u_mst.wbyte(d, ack);
      check("data ack", ack, 1'b1);
    end
    check("stretched", held > 800, 1'b1);
    rd_burst(1'b0, 3);
    u_mst.start();
    u_mst.wbyte({`ISC_ADDR_FIXED, ~pins, `ISC_DIR_WRITE}, ack);
    check("foreign ack", ack, 1'b0);
    u_mst.wbyte(8'($urandom), ack);
    check("ignored ack", ack, 1'b0);
    u_mst.stop();
    for (int p = 0; p < 4; p++) begin
      pins <= 2'(p);
      u_mst.w(10);
      rd_burst(1'b1, 1 + p % 2);
    end
    check("rx left", 9'(rxq.size()), 9'h000);
    tally_and_finish();
  end
endmodule
`default_nettype wire
